/* File: core/adcs_defines.svh */
/*
 * Constants of the 8-bit converter sequencer: register indexes, field
 * positions, reset values and timing figures.
 * Assumes it is included by bare name wherever a figure is needed.
 */
`ifndef ADCS_DEFINES_SVH
`define ADCS_DEFINES_SVH

// Clock period of hclk in ns
`define ADCS_CLK_NS 50
// Converter clock is hclk divided by this
`define ADCS_DIV 2
// Converter clock periods per conversion, and of these the sample phase
`define ADCS_CONV_CLKS 12
`define ADCS_SAMPLE_CLKS 3
`define ADCS_SAR_BITS 8
// Stabilisation time after halt wake-up, in ns
`define ADCS_STAB_NS 10000

// Register indexes; byte address is four times the index
`define ADCS_IDX_RESULT 30'h00000070
`define ADCS_IDX_CTRL 30'h00000071
`define ADCS_IDX_IRQ_STAT 30'h00000072
`define ADCS_IDX_IRQ_MASK 30'h00000073

// Control/status field positions
`define ADCS_CTL_DONE 7
`define ADCS_CTL_ON 5
`define ADCS_CTL_CH_HI 3
`define ADCS_CTL_CH_LO 0
`define ADCS_IRQ_DONE 0

// Reset values
`define ADCS_RST_BYTE 8'h00
`define ADCS_RST_WORD 32'h00000000

`endif

/* File: core/adcs_pkg.sv */
/*
 * Types shared by the converter sequencer and its approximation engine.
 * Assumes adcs_defines.svh is on the include path.
 */
`include "adcs_defines.svh"

package adcs_pkg;

	// Sequencer states, Gray along off -> run -> halted -> stab
	typedef enum logic [1:0] {
		ADCS_OFF = 2'b00,
		ADCS_RUN = 2'b01,
		ADCS_HALTED = 2'b11,
		ADCS_STAB = 2'b10
	} adcs_state_e;

	// Signals toward the analog mux and converter core
	typedef struct packed {
		logic power_on;
		logic adc_clk;
		logic sample_en;
		logic [3:0] chan;
		logic [`ADCS_SAR_BITS-1:0] trial;
	} adcs_ana_s;

	// Approximation engine state
	typedef struct packed {
		logic busy;
		logic [4:0] cnt;
		logic [`ADCS_SAR_BITS-1:0] code;
		logic [`ADCS_SAR_BITS-1:0] result;
		logic done;
	} adcs_sar_s;

	// Sequencer state
	typedef struct packed {
		adcs_state_e st;
		logic on;
		logic [3:0] chan;
		logic done_flag;
		logic [`ADCS_SAR_BITS-1:0] result;
		logic irq_stat;
		logic irq_mask;
		logic irq;
		logic [15:0] stab_cnt;
		logic ap_valid;
		logic ap_write;
		logic [29:0] ap_idx;
		logic [31:0] rdata;
	} adcs_top_s;

endpackage : adcs_pkg

/* File: core/adcs_sar.sv */
/*
 * Successive-approximation engine: sample phase, eight trial steps and
 * result hand-off, repeating until aborted.
 * Assumes the comparator output is strobed by the converter clock and so
 * arrives synchronous to hclk, valid one hclk after a trial code appears.
 */
`timescale 1ns/100ps
`include "adcs_defines.svh"

module adcs_sar
	import adcs_pkg::*;
(
	// Clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// Control from the sequencer
	input wire logic start,
	input wire logic abort,
	input wire logic cmp_hi,
	// Toward the converter core
	output logic sample_en,
	output logic adc_clk,
	output logic [`ADCS_SAR_BITS-1:0] trial,
	// Result
	output logic done,
	output logic [`ADCS_SAR_BITS-1:0] result
);

	localparam logic [4:0] LAST = 5'(`ADCS_CONV_CLKS * `ADCS_DIV - 1);
	localparam logic [4:0] SAMP = 5'(`ADCS_SAMPLE_CLKS * `ADCS_DIV);
	localparam logic [4:0] SET_LO = 5'(`ADCS_SAMPLE_CLKS * `ADCS_DIV - 1);
	localparam logic [4:0] SET_HI = 5'(SET_LO + 2 * (`ADCS_SAR_BITS - 1));
	localparam logic [4:0] DEC_LO = 5'(SET_LO + 2);
	localparam logic [4:0] DEC_HI = 5'(SET_HI + 2);
	localparam logic [2:0] TOP_BIT = 3'(`ADCS_SAR_BITS - 1);

	adcs_sar_s s_ff;
	adcs_sar_s nxt_s;
	logic [4:0] rel_set;
	logic [4:0] rel_dec;

	// Step sequencing; a start overrides an abort in the same cycle
	always_comb begin
		nxt_s = s_ff;
		nxt_s.done = 1'b0;
		rel_set = s_ff.cnt - SET_LO;
		rel_dec = s_ff.cnt - DEC_LO;
		if (start) begin
			nxt_s.busy = 1'b1;
			nxt_s.cnt = 5'h00;
			nxt_s.code = 8'h00;
		end else if (abort) begin
			nxt_s.busy = 1'b0;
			nxt_s.cnt = 5'h00;
			nxt_s.code = 8'h00;
		end else if (s_ff.busy) begin
			if (s_ff.cnt == LAST) begin
				nxt_s.result = s_ff.code; // [RL6]
				nxt_s.done = 1'b1;
				nxt_s.cnt = 5'h00; // Next sample phase follows at once [RL3]
				nxt_s.code = 8'h00;
			end else begin
				nxt_s.cnt = s_ff.cnt + 5'h01;
				// Drop the bit under test when the input lies below the trial [RL14]
				if (s_ff.cnt[0] && s_ff.cnt >= DEC_LO && s_ff.cnt <= DEC_HI && !cmp_hi) begin
					nxt_s.code[TOP_BIT - rel_dec[3:1]] = 1'b0;
				end
				// Raise the next bit to test
				if (s_ff.cnt[0] && s_ff.cnt >= SET_LO && s_ff.cnt <= SET_HI) begin
					nxt_s.code[TOP_BIT - rel_set[3:1]] = 1'b1;
				end
			end
		end
	end

	// State register
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			s_ff <= '0;
		end else begin
			s_ff <= nxt_s;
		end
	end

	// Converter clock runs at half hclk, high in the first half [RL1]
	assign adc_clk = s_ff.busy & ~s_ff.cnt[0];
	// Capacitor is connected only during the sample phase [RL14]
	assign sample_en = s_ff.busy & (s_ff.cnt < SAMP);
	assign trial = s_ff.code;
	assign done = s_ff.done;
	assign result = s_ff.result;

endmodule : adcs_sar

/* File: core/adcs_top.sv */
/*
 * Converter sequencer: AHB-Lite register slave, channel select, on/off and
 * halt control, continuous conversion and completion flag.
 * Assumes a single AHB-Lite master, word transfers only, and a converter
 * core whose comparator output is synchronous to hclk.
 */
// What this block does
// RL1: Converter clock is half of hclk; a conversion lasts twelve converter clocks.
// RL2: Four-bit channel field picks input n for value n, zero to fifteen.
// RL3: Setting the on bit starts conversions, then converts the channel continuously.
// RL4: Each finished conversion sets the done flag in the control/status register.
// RL5: Completion sets a sticky status bit; its interrupt stays off unless software unmasks it.
// RL6: Result register holds each value until the next conversion ends.
// RL7: Control/status write while on aborts, clears done, and restarts conversion.
// RL8: Done clears on result read or control/status write; software cannot set it.
// RL9: Clearing the on bit switches the converter off and stops conversions.
// RL10: Wait mode has no effect; halt disables, wake-up waits a stabilisation time.
// RL11: Software writes zero to reserved control/status bits six and four.
// RL12: Result is eight bits read-only; both registers reset to zero.
// RL13: Analog use of a pin leaves its digital input readable.
// RL14: Sample phase, then eight approximation steps with the capacitor disconnected.
// RL15: Bit six is reserved, not stored, and read as zero.
`timescale 1ns/100ps
`include "adcs_defines.svh"

module adcs_top
	import adcs_pkg::*;
#(
	parameter logic [15:0] STAB_CYCLES = 16'((`ADCS_STAB_NS + `ADCS_CLK_NS - 1) / `ADCS_CLK_NS)
)
(
	// Clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	// Power management, from same-clock logic
	input wire logic halt_req,
	// Converter core
	input wire logic cmp_hi,
	output adcs_ana_s ana,
	// Port pins keep their digital input path
	output logic [15:0] pin_digital_en,
	// Interrupt
	output logic irq
);

	adcs_top_s s_ff;
	adcs_top_s nxt_s;
	logic sar_start;
	logic sar_abort;
	logic sar_done;
	logic sar_sample;
	logic sar_clk;
	logic [`ADCS_SAR_BITS-1:0] sar_trial;
	logic [`ADCS_SAR_BITS-1:0] sar_result;
	logic wr_ctrl;
	logic rd_result;

	// Approximation engine
	adcs_sar u_sar (
		.hclk(hclk),
		.hresetn(hresetn),
		.start(sar_start),
		.abort(sar_abort),
		.cmp_hi(cmp_hi),
		.sample_en(sar_sample),
		.adc_clk(sar_clk),
		.trial(sar_trial),
		.done(sar_done),
		.result(sar_result)
	);

	// Bus decode, register update, sequencing and read capture
	always_comb begin
		nxt_s = s_ff;
		sar_start = 1'b0;
		sar_abort = 1'b0;
		wr_ctrl = s_ff.ap_valid && s_ff.ap_write && (s_ff.ap_idx == `ADCS_IDX_CTRL);
		rd_result = hsel && htrans[1] && hready && !hwrite && (haddr[31:2] == `ADCS_IDX_RESULT);

		// Address phase is taken when selected with an active transfer and the bus ready
		nxt_s.ap_valid = hsel && htrans[1] && hready;
		nxt_s.ap_write = hwrite;
		nxt_s.ap_idx = haddr[31:2];

		// Data phase writes; only the low byte carries register bits
		if (s_ff.ap_valid && s_ff.ap_write) begin
			case (s_ff.ap_idx)
				`ADCS_IDX_CTRL: begin
					nxt_s.on = hwdata[`ADCS_CTL_ON]; // [RL9]
					nxt_s.chan = hwdata[`ADCS_CTL_CH_HI:`ADCS_CTL_CH_LO]; // [RL2]
					// Bits six and four are not stored at all [RL11] [RL15]
					nxt_s.done_flag = 1'b0; // [RL8]
				end
				`ADCS_IDX_IRQ_STAT: begin
					if (hwdata[`ADCS_IRQ_DONE]) begin
						nxt_s.irq_stat = 1'b0;
					end
				end
				`ADCS_IDX_IRQ_MASK: begin
					nxt_s.irq_mask = hwdata[`ADCS_IRQ_DONE];
				end
				default: begin
					// Result register is read-only; other writes are dropped [RL12]
				end
			endcase
		end

		// Reading the result clears the flag at the address phase [RL8]
		if (rd_result) begin
			nxt_s.done_flag = 1'b0;
		end

		// Sequencer; halt overrides everything and wait mode is not seen here [RL10]
		case (s_ff.st)
			ADCS_OFF: begin
				if (halt_req) begin
					nxt_s.st = ADCS_HALTED;
				end else if (nxt_s.on) begin
					nxt_s.st = ADCS_RUN;
					sar_start = 1'b1; // [RL3]
				end
			end
			ADCS_RUN: begin
				if (halt_req) begin
					nxt_s.st = ADCS_HALTED;
					sar_abort = 1'b1; // [RL10]
				end else if (!nxt_s.on) begin
					nxt_s.st = ADCS_OFF;
					sar_abort = 1'b1; // [RL9]
				end else if (wr_ctrl) begin
					sar_start = 1'b1; // Restart from the sample phase [RL7]
				end
			end
			ADCS_HALTED: begin
				sar_abort = 1'b1;
				if (!halt_req) begin
					nxt_s.st = ADCS_STAB;
					nxt_s.stab_cnt = STAB_CYCLES;
				end
			end
			ADCS_STAB: begin
				// Analog settles before any conversion is trusted [RL10]
				if (halt_req) begin
					nxt_s.st = ADCS_HALTED;
				end else if (s_ff.stab_cnt > 16'h0001) begin
					nxt_s.stab_cnt = s_ff.stab_cnt - 16'h0001;
				end else if (nxt_s.on) begin
					nxt_s.st = ADCS_RUN;
					nxt_s.stab_cnt = 16'h0000;
					sar_start = 1'b1;
				end else begin
					nxt_s.st = ADCS_OFF;
					nxt_s.stab_cnt = 16'h0000;
				end
			end
			default: begin
				nxt_s.st = ADCS_OFF;
				sar_abort = 1'b1;
			end
		endcase

		// Completion sets last, so a clear in the same cycle loses
		if (sar_done && s_ff.st == ADCS_RUN) begin
			nxt_s.result = sar_result; // [RL6]
			nxt_s.done_flag = 1'b1; // [RL4]
			nxt_s.irq_stat = 1'b1;
		end

		// Level interrupt, off unless software unmasks it [RL5]
		nxt_s.irq = nxt_s.irq_stat & nxt_s.irq_mask;

		// Read data is captured at the address phase from the updated values; done is the held flag or a new completion
		nxt_s.rdata = `ADCS_RST_WORD;
		if (nxt_s.ap_valid && !hwrite) begin
			case (haddr[31:2])
				`ADCS_IDX_RESULT: begin
					nxt_s.rdata[`ADCS_SAR_BITS-1:0] = nxt_s.result; // [RL12]
				end
				`ADCS_IDX_CTRL: begin
					// Reserved bits read as zero [RL15]
					nxt_s.rdata[`ADCS_CTL_DONE] = s_ff.done_flag | (sar_done && s_ff.st == ADCS_RUN);
					nxt_s.rdata[`ADCS_CTL_ON] = nxt_s.on;
					nxt_s.rdata[`ADCS_CTL_CH_HI:`ADCS_CTL_CH_LO] = nxt_s.chan;
				end
				`ADCS_IDX_IRQ_STAT: begin
					nxt_s.rdata[`ADCS_IRQ_DONE] = nxt_s.irq_stat;
				end
				`ADCS_IDX_IRQ_MASK: begin
					nxt_s.rdata[`ADCS_IRQ_DONE] = nxt_s.irq_mask;
				end
				default: begin
					nxt_s.rdata = `ADCS_RST_WORD;
				end
			endcase
		end
	end

	// State register; every field resets to zero [RL12]
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			s_ff <= '0;
		end else begin
			s_ff <= nxt_s;
		end
	end

	// Bus answers: zero wait states, always OKAY
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign hrdata = s_ff.rdata;
	assign irq = s_ff.irq;

	// Analog side; power follows the on bit unless halted
	assign ana.power_on = s_ff.on && (s_ff.st != ADCS_HALTED);
	assign ana.adc_clk = sar_clk; // [RL1]
	assign ana.sample_en = sar_sample;
	assign ana.chan = s_ff.chan; // [RL2]
	assign ana.trial = sar_trial;

	// Digital input buffers are never turned off by analog use [RL13]
	assign pin_digital_en = 16'hFFFF;

endmodule : adcs_top

/* File: dv/adcs_top_checker.sv */
/* Timing checks on the converter sequencer ports.
 * Assumes one hclk domain and the bench's single bus master. */
`timescale 1ns/100ps
`include "adcs_defines.svh"

module adcs_top_checker
	import adcs_pkg::*;
#(
	parameter logic [15:0] STAB_CYCLES = 16'h0004
)
(
	// Clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// Bus
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	input wire logic [31:0] hrdata,
	// Converter side
	input wire logic halt_req,
	input wire adcs_ana_s ana,
	input wire logic [15:0] pin_digital_en
);
	localparam int STAB_N = STAB_CYCLES;
	logic taken;
	logic rose;
	logic wr_ctrl_ff;
	logic rd_ctrl_ff;
	logic samp_ff;
	logic gap_v_ff;
	logic [5:0] gap_ff;
	logic [3:0] chan_ff;

	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);

	assign taken = hsel && htrans[1] && hready;
	assign rose = ana.sample_en && !samp_ff;

	// Spacing of conversion starts; any write or power loss voids the count
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_ctrl_ff <= 1'b0;
			rd_ctrl_ff <= 1'b0;
			samp_ff <= 1'b0;
			gap_v_ff <= 1'b0;
			gap_ff <= 6'h00;
			chan_ff <= 4'h0;
		end else begin
			wr_ctrl_ff <= taken && hwrite && haddr[31:2] == `ADCS_IDX_CTRL;
			rd_ctrl_ff <= taken && !hwrite && haddr[31:2] == `ADCS_IDX_CTRL;
			samp_ff <= ana.sample_en;
			gap_ff <= rose ? 6'h01 : gap_ff + 6'h01;
			gap_v_ff <= ((taken && hwrite) || halt_req || !ana.power_on) ? 1'b0 : (rose || gap_v_ff);
			chan_ff <= wr_ctrl_ff ? hwdata[3:0] : chan_ff;
		end
	end

	sequence stab_quiet;
		!ana.sample_en[*4];
	endsequence

	rdata_idle_a: assert property (!$past(taken && !hwrite) |-> hrdata == 32'h0)
		else $error("read data outside a data phase");
	rsvd_zero_a: assert property (rd_ctrl_ff |-> hrdata[6] == 1'b0 && hrdata[4] == 1'b0 && hrdata[31:8] == 24'h0)
		else $error("reserved control bits not zero");
	pins_a: assert property (pin_digital_en == 16'hFFFF)
		else $error("digital input path lost");
	chan_sel_a: assert property (wr_ctrl_ff |-> ##2 ana.chan == chan_ff)
		else $error("channel not taken from write");
	restart_a: assert property (wr_ctrl_ff && hwdata[5] && !halt_req |=> ana.power_on ##[0:1] ana.sample_en)
		else $error("write while on did not restart");
	power_off_a: assert property (wr_ctrl_ff && !hwdata[5] |=> !ana.power_on ##1 !ana.sample_en[*8])
		else $error("converter kept running when off");
	halt_off_a: assert property (halt_req |=> !ana.power_on)
		else $error("converter powered in halt");
	stab_wait_a: assert property ($fell(halt_req) |-> stab_quiet ##[1:STAB_N] ana.sample_en)
		else $error("wake-up wait wrong");
	clk_half_a: assert property (ana.sample_en && gap_v_ff |=> ana.adc_clk != $past(ana.adc_clk))
		else $error("converter clock not half rate");
	conv_period_a: assert property (rose && gap_v_ff |-> gap_ff == 6'h18)
		else $error("conversion not 24 cycles");
	conv_again_a: assert property (gap_v_ff |-> gap_ff <= 6'h18)
		else $error("conversions not continuous");
	sample_len_a: assert property ($fell(ana.sample_en) && ana.power_on && gap_v_ff |-> $past(ana.sample_en, 6) && !$past(ana.sample_en, 7))
		else $error("sample phase length wrong");
endmodule : adcs_top_checker

/* File: dv/adcs_conv_model.sv */
/* Analog mux and converter core model with one level per channel.
 * Assumes the trial code is registered on hclk. */
`timescale 1ns/100ps

module adcs_conv_model
	import adcs_pkg::*;
(
	// Clock
	input wire logic hclk,
	// From the sequencer
	input wire adcs_ana_s ana,
	input wire logic [15:0][7:0] levels,
	// Comparator
	output logic cmp_hi
);
	logic [7:0] held_ff;
	logic junk_ff = 1'b0;

	// Capacitor follows the chosen input only while sampling
	always @(posedge hclk) begin
		junk_ff <= !junk_ff;
		if (ana.power_on && ana.sample_en) begin
			held_ff <= levels[ana.chan];
		end
	end

	// An unpowered comparator gives no usable answer, so it wanders
	assign cmp_hi = ana.power_on ? (held_ff >= ana.trial) : junk_ff;
endmodule : adcs_conv_model

/* File: dv/tb_adc_sequencer_8bit.sv */
/* Register-level bench of the converter sequencer.
 * Assumes the converter model and the checker compiled beforehand. */
`timescale 1ns/100ps
`include "adcs_defines.svh"
`define CHK(nm, ex, got) begin check_count++; if ((got) !== (ex)) begin err_count++; \
	$display("CHECK FAILED %s expected %h seen %h", nm, ex, got); end end

module tb_adc_sequencer_8bit
	import adcs_pkg::*;
;
	localparam logic [15:0] STAB = 16'h0004;
	localparam logic [31:0] A_RES = {`ADCS_IDX_RESULT, 2'b00};
	localparam logic [31:0] A_CTL = {`ADCS_IDX_CTRL, 2'b00};
	localparam logic [31:0] A_STAT = {`ADCS_IDX_IRQ_STAT, 2'b00};
	localparam logic [31:0] A_MASK = {`ADCS_IDX_IRQ_MASK, 2'b00};
	logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, halt_req = 1'b0;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
	logic [1:0] htrans = 2'b00;
	logic [2:0] hsize = 3'b010;
	logic hready, hreadyout, hresp, cmp_hi, irq;
	logic [15:0] pin_digital_en;
	logic [15:0][7:0] levels;
	adcs_ana_s ana;
	int err_count = 0, check_count = 0, n;

	assign hready = hreadyout;
	always #25 hclk = ~hclk;

	adcs_top #(.STAB_CYCLES(STAB)) i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .halt_req(halt_req), .cmp_hi(cmp_hi),
		.ana(ana), .pin_digital_en(pin_digital_en), .irq(irq));
	adcs_conv_model i_conv (.hclk(hclk), .ana(ana), .levels(levels), .cmp_hi(cmp_hi));

	task automatic complete_run;
		if (err_count == 0 && check_count > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask : complete_run

	// Bounded wait for an edge with hready high
	task automatic wrdy;
		int k;
		k = 0;
		do begin
			@(posedge hclk);
			k++;
		end while (hready !== 1'b1 && k < 40);
		if (hready !== 1'b1) begin
			err_count++;
			complete_run();
		end
	endtask : wrdy

	// Data phase: read data and ready are taken mid-cycle, where they are settled
	task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d, output logic [31:0] r);
		int k;
		logic ok;
		hsel <= 1'b1;
		haddr <= a;
		hwrite <= w;
		htrans <= 2'b10;
		wrdy();
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= d;
		k = 0;
		ok = 1'b0;
		do begin
			@(negedge hclk);
			r = hrdata;
			ok = (hready === 1'b1);
			@(posedge hclk);
			k++;
		end while (!ok && k < 40);
		if (!ok) begin
			err_count++;
			complete_run();
		end
	endtask : bus

	task automatic ck(input logic [31:0] a, input logic [31:0] ex, input string nm);
		logic [31:0] r;
		bus(1'b0, a, 32'h0, r);
		`CHK(nm, ex, r)
	endtask : ck

	// Poll the done bit; reading control does not clear it
	task automatic poll;
		logic [31:0] r;
		int k;
		k = 0;
		r = 32'h0;
		while (r[7] !== 1'b1 && k < 40) begin
			bus(1'b0, A_CTL, 32'h0, r);
			k++;
		end
		if (r[7] !== 1'b1) begin
			err_count++;
			complete_run();
		end
	endtask : poll

	initial begin
		repeat (100000) @(posedge hclk);
		err_count++;
		complete_run();
	end

	initial begin
		for (int i = 0; i < 16; i++) levels[i] = 8'(i * 17);
		repeat (8) @(posedge hclk);
		hresetn <= 1'b1;
		ck(A_RES, 32'h0, "result reset");
		ck(A_CTL, 32'h0, "ctrl reset");
		ck(32'h000001D0, 32'h0, "unmapped");
		// Every channel, from 00h to FFh levels
		for (int i = 0; i < 16; i++) begin
			bus(1'b1, A_CTL, 32'h20 | 32'(i), rd);
			ck(A_CTL, 32'h20 | 32'(i), "ctrl after write");
			poll();
			ck(A_RES, 32'(levels[i]), "result");
			ck(A_CTL, 32'h20 | 32'(i), "done after read");
		end
		`CHK("irq idle", 1'b0, irq)
		// Result holds until the next conversion ends
		levels[15] <= 8'h3C;
		ck(A_RES, 32'hFF, "result held");
		poll();
		bus(1'b0, A_RES, 32'h0, rd);
		poll();
		ck(A_RES, 32'h3C, "result updated");
		// Done cannot be written; off stops conversions
		bus(1'b1, A_CTL, 32'h85, rd);
		repeat (60) @(posedge hclk);
		ck(A_CTL, 32'h05, "ctrl stopped");
		// Rewrite mid-conversion aborts the old channel
		bus(1'b1, A_CTL, 32'h22, rd);
		repeat (14) @(posedge hclk);
		bus(1'b1, A_CTL, 32'h29, rd);
		poll();
		ck(A_RES, 32'(levels[9]), "restarted result");
		// No completion while halted, conversions resume after wake-up
		halt_req <= 1'b1;
		bus(1'b0, A_RES, 32'h0, rd);
		repeat (40) @(posedge hclk);
		ck(A_CTL, 32'h29, "halted");
		halt_req <= 1'b0;
		poll();
		// Completion event: sticky status, mask, clear
		bus(1'b1, A_STAT, 32'h1, rd);
		bus(1'b1, A_MASK, 32'h1, rd);
		n = 0;
		while (irq !== 1'b1 && n < 60) begin
			@(negedge hclk);
			n++;
		end
		`CHK("irq raised", 1'b1, irq)
		@(posedge hclk);
		bus(1'b1, A_MASK, 32'h0, rd);
		ck(A_STAT, 32'h1, "status sticky");
		`CHK("irq masked", 1'b0, irq)
		bus(1'b1, A_CTL, 32'h0, rd);
		bus(1'b1, A_STAT, 32'h1, rd);
		ck(A_STAT, 32'h0, "status cleared");
		complete_run();
	end
endmodule : tb_adc_sequencer_8bit

bind adcs_top adcs_top_checker #(.STAB_CYCLES(STAB_CYCLES)) i_chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
	.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
	.halt_req(halt_req), .ana(ana), .pin_digital_en(pin_digital_en));
